// ### rtl/roc_calibration_counter.sv
// Ring-oscillator calibration counter with trim control and register slave.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Count every reference cycle during calibration window.
// - Tally register holds final result after completion.
// - Trim register accepts half-word or word writes only.
// - Trim register untouched by sleep entry or exit.
// - Coarse trim bits 9-12, reset 0x6, output.
// - Fine trim bits 4-8, reset 0x17, output.
// - Bit 0 switches ring oscillator on/off.
// - Run bit starts; self-clears and sets done.
// - Writing run zero mid-calibration aborts it.
// - Sixteen-bit window length in ring cycles.
// - Irq enable with done mask bit raises request on completion.
module roc_calibration_counter #(
	parameter int TALLY_W = 32 // Width of the reference tally.
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Power state: high while the device sleeps.
	input wire logic sleep_in,
	// Ring oscillator clock, asynchronous to clk_in.
	input wire logic ring_clk_in,
	// Register bus.
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [1:0] wsize_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// Ring oscillator trim outputs.
	output logic [3:0] ring_coarse_trim_out,
	output logic [4:0] ring_fine_trim_out,
	output logic ring_osc_on_out,
	// Calibration state and interrupt.
	output logic cal_busy_out,
	output logic irq_out
);

	// ==========================================================
	// Request bundle
	// ==========================================================
	roc_pkg::roc_req_t req; // Current bus request.
	assign req.wr = wr_in;
	assign req.rd = rd_in;
	assign req.addr = addr_in;
	assign req.wdata = wdata_in;
	assign req.size = roc_pkg::roc_size_t'(wsize_in);

	// Register state.
	roc_pkg::roc_trim_t trim_q; // Trim control register.
	logic [15:0] window_q; // Calibration window in ring cycles.
	logic run_q; // Calibration run bit.
	logic ien_q; // Calibration interrupt enable.
	logic [TALLY_W-1:0] tally_q; // Final tally visible to software.
	logic [TALLY_W-1:0] count_q; // Running reference cycle counter.
	logic [15:0] edges_q; // Ring rising edges seen in this window.
	logic [roc_pkg::EVT_W-1:0] status_q; // Sticky events.
	logic [roc_pkg::EVT_W-1:0] mask_q; // Event mask.
	roc_pkg::roc_state_t state_q; // Calibration sequencer state.
	logic [2:0] ring_sync_q; // Three-stage synchroniser for the ring clock.
	logic ring_level_q; // Accepted ring clock level.

	// Decoded strobes.
	logic wr_ctrl;
	logic wr_trim_lo;
	logic wr_status;
	logic wr_mask;
	logic ring_rise;
	logic finish;
	logic abort;
	logic start;
	assign wr_ctrl = req.wr && (req.addr == roc_pkg::ADDR_CAL_CTRL);
	// Byte writes to the trim register are dropped; an upper half-word write only touches
	// reserved bits and so changes nothing.
	assign wr_trim_lo = req.wr && (req.addr == roc_pkg::ADDR_TRIM)
		&& ((req.size == roc_pkg::ROC_SIZE_WORD)
		|| ((req.size == roc_pkg::ROC_SIZE_HALF) && !req.addr[roc_pkg::HALF_SEL_BIT]));
	assign wr_status = req.wr && (req.addr == roc_pkg::ADDR_IRQ_STATUS);
	assign wr_mask = req.wr && (req.addr == roc_pkg::ADDR_IRQ_MASK);

	// ==========================================================
	// Ring clock synchroniser
	// ==========================================================
	// The ring clock is a foreign signal; only stages two and three are compared, so the
	// first stage never feeds decision logic.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			ring_sync_q <= 3'h0;
		end
		else
		begin
			ring_sync_q <= {ring_sync_q[1:0], ring_clk_in};
		end
	end

	// A new level is accepted once the second and third stage agree.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			ring_level_q <= 1'b0;
		end
		else if (ring_sync_q[1] == ring_sync_q[2])
		begin
			ring_level_q <= ring_sync_q[2];
		end
	end
	assign ring_rise = (ring_sync_q[1] == ring_sync_q[2]) && ring_sync_q[2] && !ring_level_q;

	// ==========================================================
	// Sequencer control
	// ==========================================================
	assign start = wr_ctrl && req.wdata[roc_pkg::CAL_RUN_BIT] && (state_q == roc_pkg::ROC_IDLE);
	assign abort = wr_ctrl && !req.wdata[roc_pkg::CAL_RUN_BIT]
		&& (state_q != roc_pkg::ROC_IDLE);
	// A window of zero is treated like a window of one ring cycle.
	assign finish = (state_q == roc_pkg::ROC_COUNT) && ring_rise && !abort
		&& ((edges_q + 16'h0001) >= window_q);

	// Sequencer: arm on start, count from the first ring edge, stop after the window.
	always_ff @(posedge clk_in)
	begin
		if (reset_in || sleep_in)
		begin
			state_q <= roc_pkg::ROC_IDLE;
		end
		else
		begin
			case (state_q)
				roc_pkg::ROC_IDLE:
				begin
					if (start)
					begin
						state_q <= roc_pkg::ROC_ARM;
					end
				end
				roc_pkg::ROC_ARM:
				begin
					// Waiting for a ring edge aligns the window to whole ring cycles.
					if (abort)
					begin
						state_q <= roc_pkg::ROC_IDLE;
					end
					else if (ring_rise)
					begin
						state_q <= roc_pkg::ROC_COUNT;
					end
				end
				roc_pkg::ROC_COUNT:
				begin
					if (abort || finish)
					begin
						state_q <= roc_pkg::ROC_IDLE;
					end
				end
				default:
				begin
					state_q <= roc_pkg::ROC_IDLE;
				end
			endcase
		end
	end

	// Ring edge counter for the window length.
	always_ff @(posedge clk_in)
	begin
		if (reset_in || start)
		begin
			edges_q <= 16'h0000;
		end
		else if ((state_q == roc_pkg::ROC_COUNT) && ring_rise)
		begin
			edges_q <= edges_q + 16'h0001;
		end
	end

	// Reference counter: clk_in is the reference clock, so every cycle in the window counts.
	always_ff @(posedge clk_in)
	begin
		if (reset_in || start)
		begin
			count_q <= '0;
		end
		else if (state_q == roc_pkg::ROC_COUNT)
		begin
			count_q <= count_q + TALLY_W'(1);
		end
	end

	// Final tally: loaded only at completion so a read never sees a partial count. Counter
	// and register share one clock, so the result is loaded on the same edge that sets done.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			tally_q <= '0;
		end
		else if (finish)
		begin
			tally_q <= count_q + TALLY_W'(1);
		end
	end

	// ==========================================================
	// Calibration control register
	// ==========================================================
	// This register is not retained through sleep; it clears on sleep.
	always_ff @(posedge clk_in)
	begin
		if (reset_in || sleep_in)
		begin
			window_q <= 16'h0000;
			run_q <= 1'b0;
			ien_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				window_q <= req.wdata[roc_pkg::CAL_WINDOW_W-1:0];
				ien_q <= req.wdata[roc_pkg::CALIBRATION_IRQ_ENABLE_BIT];
			end
			if (finish || abort)
			begin
				run_q <= 1'b0;
			end
			else if (wr_ctrl)
			begin
				run_q <= req.wdata[roc_pkg::CAL_RUN_BIT];
			end
		end
	end

	// ==========================================================
	// Trim control register
	// ==========================================================
	// Only reset_in clears it; sleep_in is deliberately not used here.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			trim_q.coarse <= roc_pkg::COARSE_RESET;
			trim_q.fine <= roc_pkg::FINE_RESET;
			trim_q.on <= roc_pkg::ON_RESET;
		end
		else if (wr_trim_lo)
		begin
			trim_q.coarse <= req.wdata[roc_pkg::TRIM_COARSE_LSB +: roc_pkg::TRIM_COARSE_W];
			trim_q.fine <= req.wdata[roc_pkg::TRIM_FINE_LSB +: roc_pkg::TRIM_FINE_W];
			trim_q.on <= req.wdata[roc_pkg::TRIM_ON_BIT];
		end
	end

	// Trim outputs, registered copies of the trim register.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			ring_coarse_trim_out <= roc_pkg::COARSE_RESET;
			ring_fine_trim_out <= roc_pkg::FINE_RESET;
			ring_osc_on_out <= roc_pkg::ON_RESET;
		end
		else
		begin
			ring_coarse_trim_out <= trim_q.coarse;
			ring_fine_trim_out <= trim_q.fine;
			ring_osc_on_out <= trim_q.on;
		end
	end

	// ==========================================================
	// Events and interrupt
	// ==========================================================
	// A new event in the same cycle as its write-one clear survives.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			status_q <= '0;
		end
		else
		begin
			status_q[roc_pkg::EVT_DONE_BIT] <= finish
				|| (status_q[roc_pkg::EVT_DONE_BIT]
				&& !(wr_status && req.wdata[roc_pkg::EVT_DONE_BIT]));
			status_q[roc_pkg::EVT_ABORT_BIT] <= abort
				|| (status_q[roc_pkg::EVT_ABORT_BIT]
				&& !(wr_status && req.wdata[roc_pkg::EVT_ABORT_BIT]));
		end
	end

	// Mask register, plain read and write.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			mask_q <= '0;
		end
		else if (wr_mask)
		begin
			mask_q <= req.wdata[roc_pkg::EVT_W-1:0];
		end
	end

	// The done event reaches the line only with the calibration enable as well as the mask.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			irq_out <= 1'b0;
			cal_busy_out <= 1'b0;
		end
		else
		begin
			irq_out <= (status_q[roc_pkg::EVT_DONE_BIT] && mask_q[roc_pkg::EVT_DONE_BIT]
				&& ien_q)
				|| (status_q[roc_pkg::EVT_ABORT_BIT] && mask_q[roc_pkg::EVT_ABORT_BIT]);
			cal_busy_out <= (state_q != roc_pkg::ROC_IDLE);
		end
	end

	// ==========================================================
	// Read data
	// ==========================================================
	// Read data appear the cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			rdata_out <= 32'h0000_0000;
		end
		else if (req.rd)
		begin
			case (req.addr)
				roc_pkg::ADDR_CAL_CTRL:
				begin
					rdata_out <= {14'h0000, ien_q, run_q, window_q};
				end
				roc_pkg::ADDR_TALLY:
				begin
					rdata_out <= 32'(tally_q);
				end
				roc_pkg::ADDR_TRIM:
				begin
					rdata_out <= {19'h00000, trim_q.coarse, trim_q.fine, 3'h0, trim_q.on};
				end
				roc_pkg::ADDR_IRQ_STATUS:
				begin
					rdata_out <= {30'h00000000, status_q};
				end
				roc_pkg::ADDR_IRQ_MASK:
				begin
					rdata_out <= {30'h00000000, mask_q};
				end
				default:
				begin
					rdata_out <= 32'h0000_0000;
				end
			endcase
		end
		else
		begin
			rdata_out <= 32'h0000_0000;
		end
	end

endmodule : roc_calibration_counter

`default_nettype wire

// ### pkg/roc_pkg.sv
// Package of constants and types for the ring-oscillator calibration counter.
package roc_pkg;

	// ==========================================================
	// Register byte offsets
	// ==========================================================
	localparam logic [7:0] ADDR_CAL_CTRL = 8'h34; // Calibration window, run and irq enable.
	localparam logic [7:0] ADDR_TALLY = 8'h38; // Reference cycle tally, read only.
	localparam logic [7:0] ADDR_TRIM = 8'h3c; // Ring oscillator trim and on control.
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h48; // Sticky event bits, write one to clear.
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h4c; // Event mask, same layout as status.

	// ==========================================================
	// Field positions and reset values
	// ==========================================================
	localparam int TRIM_ON_BIT = 0; // Ring oscillator on bit.
	localparam int TRIM_FINE_LSB = 4; // Fine trim occupies bits 4 to 8.
	localparam int TRIM_FINE_W = 5; // Fine trim width.
	localparam int TRIM_COARSE_LSB = 9; // Coarse trim occupies bits 9 to 12.
	localparam int TRIM_COARSE_W = 4; // Coarse trim width.
	localparam logic [3:0] COARSE_RESET = 4'h6; // Coarse trim after reset.
	localparam logic [4:0] FINE_RESET = 5'h17; // Fine trim after reset.
	localparam logic ON_RESET = 1'b1; // Ring oscillator runs after reset.
	localparam int CAL_WINDOW_W = 16; // Window length field, bits 0 to 15.
	localparam int CAL_RUN_BIT = 16; // Calibration run bit.
	localparam int CALIBRATION_IRQ_ENABLE_BIT = 17; // Calibration interrupt enable bit.
	localparam int EVT_DONE_BIT = 0; // Status bit set when a calibration completes.
	localparam int EVT_ABORT_BIT = 1; // Status bit set when a calibration is aborted.
	localparam int EVT_W = 2; // Number of event bits.
	localparam int HALF_SEL_BIT = 1; // Address bit that picks the upper half word.

	// ==========================================================
	// Types
	// ==========================================================
	// Access size that accompanies a write.
	typedef enum logic [1:0] {
		ROC_SIZE_BYTE = 2'h0,
		ROC_SIZE_HALF = 2'h1,
		ROC_SIZE_WORD = 2'h2
	} roc_size_t;

	// One register bus request as seen in a single cycle.
	typedef struct packed {
		logic wr; // Write strobe.
		logic rd; // Read strobe.
		logic [7:0] addr; // Byte address.
		logic [31:0] wdata; // Write data.
		roc_size_t size; // Write access size.
	} roc_req_t;

	// Trim settings presented to the ring oscillator.
	typedef struct packed {
		logic [3:0] coarse; // Coarse load, 1 pF per step.
		logic [4:0] fine; // Fine load, 160 fF per step.
		logic on; // Oscillator running.
	} roc_trim_t;

	// Calibration state, one-hot.
	typedef enum logic [2:0] {
		ROC_IDLE = 3'h1,
		ROC_ARM = 3'h2,
		ROC_COUNT = 3'h4
	} roc_state_t;

endpackage : roc_pkg

// ### verification/roc_chk.sv
// Checker of trim, calibration and interrupt behaviour at the block ports.
`timescale 1ns/1ps
`default_nettype none
module roc_chk #(
	parameter int TALLY_W = 32 // Width of the reference tally.
) (
	// Clock, reset and power state.
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic sleep_in,
	input wire logic ring_clk_in,
	// Register bus.
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [1:0] wsize_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	// Trim, state and interrupt outputs.
	input wire logic [3:0] ring_coarse_trim_out,
	input wire logic [4:0] ring_fine_trim_out,
	input wire logic ring_osc_on_out,
	input wire logic cal_busy_out,
	input wire logic irq_out
);
	// ==========
	// Helpers and assertions, all in the one clock domain.
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	logic [9:0] trim_bits; // The trim pins gathered for stability tests.
	logic ctrl_wr; // A word write to the calibration control register.
	assign trim_bits = {ring_coarse_trim_out, ring_fine_trim_out, ring_osc_on_out};
	assign ctrl_wr = wr_in && addr_in == roc_pkg::ADDR_CAL_CTRL
		&& wsize_in == roc_pkg::ROC_SIZE_WORD;
	chk_reserved_zero: assert property (rd_in && addr_in == roc_pkg::ADDR_TRIM
		|=> rdata_out[31:13] == 19'h0 && rdata_out[3:1] == 3'h0)
		else $error("reserved trim bits not zero");
	chk_byte_ignored: assert property (wr_in && addr_in == roc_pkg::ADDR_TRIM
		&& wsize_in == roc_pkg::ROC_SIZE_BYTE && !$past(wr_in) |=> ##1 $stable(trim_bits))
		else $error("byte write changed trim");
	// Half and word writes at the low half both carry bits 0 to 12.
	chk_trim_write: assert property (wr_in && addr_in == roc_pkg::ADDR_TRIM
		&& (wsize_in == roc_pkg::ROC_SIZE_WORD || wsize_in == roc_pkg::ROC_SIZE_HALF)
		|=> ##1 trim_bits == {$past(wdata_in[12:4], 2), $past(wdata_in[0], 2)})
		else $error("trim pins do not follow write");
	// Sleep is not a write, so the pins must hold through it.
	chk_trim_hold: assert property (!wr_in |=> ##1 $stable(trim_bits))
		else $error("trim pins moved without write");
	chk_run_starts: assert property (ctrl_wr && wdata_in[16] && !cal_busy_out
		&& !sleep_in |=> ##1 cal_busy_out)
		else $error("run bit did not start calibration");
	chk_abort_idle: assert property (ctrl_wr && !wdata_in[16] && cal_busy_out
		|=> ##1 !cal_busy_out)
		else $error("abort did not stop calibration");
	// Without a recent register write, the request can only come from an event.
	chk_irq_cause: assert property ($rose(irq_out) && !$past(wr_in, 2)
		|-> $fell(cal_busy_out))
		else $error("interrupt rose without calibration end");
	chk_irq_clear: assert property (wr_in && addr_in == roc_pkg::ADDR_IRQ_STATUS
		&& wdata_in[1:0] == 2'h3 && !cal_busy_out |=> ##1 !irq_out)
		else $error("interrupt stayed after clearing");
endmodule : roc_chk
bind roc_calibration_counter roc_chk #(.TALLY_W(TALLY_W)) i_roc_chk (
	.clk_in(clk_in), .reset_in(reset_in), .sleep_in(sleep_in), .ring_clk_in(ring_clk_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wsize_in(wsize_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .ring_coarse_trim_out(ring_coarse_trim_out),
	.ring_fine_trim_out(ring_fine_trim_out), .ring_osc_on_out(ring_osc_on_out),
	.cal_busy_out(cal_busy_out), .irq_out(irq_out));
`default_nettype wire

// ### verification/roc_calibration_counter_test.sv
// Self-checking testbench of the ring-oscillator calibration counter.
`timescale 1ns/1ps
`default_nettype none
module roc_calibration_counter_test;
	// ==========
	// Signals, counters and the table of trim writes.
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic sleep_in = 1'b0;
	logic ring_clk_in = 1'b0; // Ring period is 40 reference cycles.
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic [1:0] wsize_in = 2'h2;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic [3:0] ring_coarse_trim_out;
	logic [4:0] ring_fine_trim_out;
	logic ring_osc_on_out;
	logic cal_busy_out;
	logic irq_out;
	logic [31:0] trim_pins; // Pins laid out as the trim register.
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int ring_div = 0; // Reference cycles since the last ring pin toggle.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		roc_pkg::roc_size_t size;
		logic [12:0] expect_trim;
	} roc_row_t;
	roc_row_t rows [6] = '{
		'{8'h3c, 32'hffffffff, roc_pkg::ROC_SIZE_WORD, 13'h1ff1},
		'{8'h3c, 32'h00000000, roc_pkg::ROC_SIZE_HALF, 13'h0000},
		'{8'h3c, 32'hffffffff, roc_pkg::ROC_SIZE_BYTE, 13'h0000},
		'{8'h3e, 32'hffffffff, roc_pkg::ROC_SIZE_HALF, 13'h0000},
		'{8'h3c, 32'h00000a51, roc_pkg::ROC_SIZE_WORD, 13'h0a51},
		'{8'h3c, 32'hffff2c61, roc_pkg::ROC_SIZE_HALF, 13'h0c61}};
	assign trim_pins = {19'h0, ring_coarse_trim_out, ring_fine_trim_out, 3'h0, ring_osc_on_out};
	roc_calibration_counter #(.TALLY_W(32)) i_roc_calibration_counter (
		.clk_in(clk_in), .reset_in(reset_in), .sleep_in(sleep_in), .ring_clk_in(ring_clk_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wsize_in(wsize_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .ring_coarse_trim_out(ring_coarse_trim_out),
		.ring_fine_trim_out(ring_fine_trim_out), .ring_osc_on_out(ring_osc_on_out),
		.cal_busy_out(cal_busy_out), .irq_out(irq_out));
	// ==========
	// Clocks; the ring pin toggles every 20 reference cycles, driven like any other input.
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		if (ring_div == 19)
		begin
			ring_div <= 0;
			ring_clk_in <= ~ring_clk_in;
		end
		else
		begin
			ring_div <= ring_div + 1;
		end
	end
	// A hang ends the run as a failure.
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	// ==========
	// Bus and comparison tasks.
	task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
		checks_done++;
		if (got !== expv)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, expv, got);
		end
	endtask : check
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] s = roc_pkg::ROC_SIZE_WORD);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		wsize_in <= s;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : bus_wr
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] expv, input string what);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		check(what, expv, rdata_out);
	endtask : rd_chk
	// The ring period is a whole number of reference cycles, so the tally is exact.
	task automatic tally_chk(input int expv);
		rd_chk(roc_pkg::ADDR_TALLY, 32'(expv), "tally");
	endtask : tally_chk
	task automatic run_cal(input logic [31:0] ctrl);
		int k;
		k = 0;
		bus_wr(roc_pkg::ADDR_CAL_CTRL, ctrl);
		@(posedge clk_in);
		#1;
		check("busy", 32'h1, {31'h0, cal_busy_out});
		while (cal_busy_out !== 1'b0 && k < 6000)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		// A sequence that never ends is counted here, well inside the run limit.
		check("busy end", 32'h0, {31'h0, cal_busy_out});
		@(posedge clk_in);
		#1;
	endtask : run_cal
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// ==========
	// Main sequence: reset values, trim table, sleep, calibrations, abort.
	initial
	begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_chk(roc_pkg::ADDR_TRIM, 32'h00000d71, "trim reset");
		check("trim pins reset", 32'h00000d71, trim_pins);
		rd_chk(roc_pkg::ADDR_TALLY, 32'h0, "tally reset");
		rd_chk(8'h50, 32'h0, "unmapped read");
		foreach (rows[i])
		begin
			bus_wr(rows[i].addr, rows[i].data, rows[i].size);
			rd_chk(roc_pkg::ADDR_TRIM, {19'h0, rows[i].expect_trim}, "trim read");
			check("trim pins", {19'h0, rows[i].expect_trim}, trim_pins);
		end
		// Sleep drops the calibration control but must keep the trim.
		bus_wr(roc_pkg::ADDR_CAL_CTRL, 32'h5);
		@(posedge clk_in);
		sleep_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		sleep_in <= 1'b0;
		rd_chk(roc_pkg::ADDR_TRIM, 32'h00000c61, "trim after sleep");
		rd_chk(roc_pkg::ADDR_CAL_CTRL, 32'h0, "control after sleep");
		// Window of three ring cycles with the interrupt enabled.
		bus_wr(roc_pkg::ADDR_IRQ_MASK, 32'h3);
		run_cal(32'h00030003);
		tally_chk(120);
		rd_chk(roc_pkg::ADDR_CAL_CTRL, 32'h00020003, "run cleared");
		rd_chk(roc_pkg::ADDR_IRQ_STATUS, 32'h1, "done flag");
		check("irq done", 32'h1, {31'h0, irq_out});
		bus_wr(roc_pkg::ADDR_IRQ_STATUS, 32'h3);
		@(posedge clk_in);
		#1;
		check("irq cleared", 32'h0, {31'h0, irq_out});
		// Zero window acts as one; no request without the enable.
		run_cal(32'h00010000);
		tally_chk(40);
		rd_chk(roc_pkg::ADDR_IRQ_STATUS, 32'h1, "done without irq");
		check("irq disabled", 32'h0, {31'h0, irq_out});
		bus_wr(roc_pkg::ADDR_IRQ_STATUS, 32'h1);
		// Abort mid-window leaves the last result in place.
		bus_wr(roc_pkg::ADDR_CAL_CTRL, 32'h00030064);
		repeat (200) @(posedge clk_in);
		bus_wr(roc_pkg::ADDR_CAL_CTRL, 32'h00020064);
		repeat (3) @(posedge clk_in);
		#1;
		check("busy after abort", 32'h0, {31'h0, cal_busy_out});
		check("irq abort", 32'h1, {31'h0, irq_out});
		rd_chk(roc_pkg::ADDR_IRQ_STATUS, 32'h2, "abort flag");
		tally_chk(40);
		bus_wr(roc_pkg::ADDR_IRQ_MASK, 32'h1);
		@(posedge clk_in);
		#1;
		check("irq masked", 32'h0, {31'h0, irq_out});
		bus_wr(roc_pkg::ADDR_IRQ_STATUS, 32'h2);
		rd_chk(roc_pkg::ADDR_IRQ_STATUS, 32'h0, "status cleared");
		test_done();
	end
endmodule : roc_calibration_counter_test
`default_nettype wire
